//--- serial_host_command_slave.sv
// Operation
// - Slave address is 40h with strap low, 50h with strap high.
// - Strap is caught as reset releases and held until next reset.
// - Configuration registers are written by the host only through this port.
// - START: SDA falls while SCL is high.
// - STOP: SDA rises while SCL is high.
// - Driver of SDA changes it only while SCL is low.
// - Each packet is eight data bits then one acknowledge bit.
// - Bytes travel most significant bit first.
// - Transmitter releases SDA during the acknowledge bit.
// - Receiver pulls SDA low in the acknowledge bit to confirm the byte.
// - SCL may run anywhere from 50 KHz to 1 MHz.
// - Slave logic runs from the crystal clock input.
// - Serial pins keep working regardless of power-down state.
module serial_host_command_slave (
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire logic                      clk_en,
  input  wire logic                      cfg_clk,
  input  wire logic                      address_select_strap,
  input  wire serial_port_pkg::bus_pins_t bus_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  output serial_port_pkg::cfg_write_t    cfg_word,
  output logic                           cfg_valid,
  input  wire logic                      cfg_ready,
  output logic                     [7:0] slave_address,
  output logic                           bus_active
);
  import serial_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        scl_meta_reg;
  logic        scl_sync_reg;
  logic        scl_prev_reg;
  logic        sda_meta_reg;
  logic        sda_sync_reg;
  logic        sda_prev_reg;
  logic        strap_meta_reg;
  logic        strap_sync_reg;
  logic        reset_seen_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_evt;
  logic        stop_evt;
  link_state_t state_reg;
  logic  [3:0] bit_cnt_reg;
  logic  [7:0] rx_reg;
  logic  [7:0] tx_reg;
  logic  [7:0] index_reg;
  logic        read_reg;
  logic        host_ack_reg;
  logic        push_reg;
  logic        sda_oe_reg;
  logic  [7:0] mem_rdata;
  logic  [1:0] wbin_reg;
  logic  [1:0] wgray_reg;
  logic  [1:0] rgray_meta_reg;
  logic  [1:0] rgray_sync_reg;
  logic        buf_full;
  cfg_write_t  buf_mem [0:BUF_DEPTH-1];
  logic        cfg_rst_meta_reg;
  logic        cfg_rst_reg;
  logic  [1:0] rbin_reg;
  logic  [1:0] rgray_reg;
  logic  [1:0] wgray_meta_reg;
  logic  [1:0] wgray_sync_reg;
  logic        buf_empty;
  logic        pop;
  logic  [1:0] wbin_next;
  logic  [1:0] rbin_next;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; no reset, first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      scl_meta_reg   <= bus_in.scl;
      scl_sync_reg   <= scl_meta_reg;
      sda_meta_reg   <= bus_in.sda;
      sda_sync_reg   <= sda_meta_reg;
      strap_meta_reg <= address_select_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (clk_en) begin
      scl_prev_reg <= scl_sync_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // Pin sampling and protocol engine run on the crystal clock; 1 MHz SCL still gives 12 cycles per half
  assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
  assign start_evt = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_evt  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture at reset release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reset_seen_reg <= 1'b1;
      slave_address  <= ADDR_STRAP_LOW;
    end else if (clk_en) begin
      reset_seen_reg <= 1'b0;
      if (reset_seen_reg) begin
        slave_address <= strap_sync_reg ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  // No power-down input reaches this engine, so the pins stay live
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= BIT_COUNT_ZERO;
      rx_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      index_reg    <= 8'h00;
      read_reg     <= 1'b0;
      host_ack_reg <= 1'b0;
      push_reg     <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (clk_en) begin
      push_reg <= 1'b0;
      if (start_evt) begin
        // Repeated START lands here too and restarts address phase
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= BIT_COUNT_ZERO;
        sda_oe_reg  <= 1'b0;
      end else if (stop_evt) begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_INDEX, ST_WDATA: begin
            if (scl_rise) begin
              rx_reg      <= {rx_reg[MSB-1:0], sda_sync_reg};
              bit_cnt_reg <= bit_cnt_reg + BIT_COUNT_ONE;
            end else if (scl_fall && bit_cnt_reg == BIT_COUNT_FULL) begin
              bit_cnt_reg <= BIT_COUNT_ZERO;
              // All SDA changes are made on the SCL falling edge
              if (state_reg == ST_ADDR) begin
                if (addr_match(rx_reg, slave_address)) begin
                  sda_oe_reg <= 1'b1;
                  read_reg   <= rx_reg[0];
                  state_reg  <= ST_ACK_ADDR;
                end else begin
                  state_reg <= ST_IGNORE;
                end
              end else if (state_reg == ST_INDEX) begin
                index_reg  <= rx_reg;
                sda_oe_reg <= 1'b1;
                state_reg  <= ST_ACK_INDEX;
              end else if (!buf_full) begin
                // Data byte is taken only when the buffer has room
                sda_oe_reg <= 1'b1;
                push_reg   <= 1'b1;
                state_reg  <= ST_ACK_WDATA;
              end else begin
                // Full buffer: leave SDA released so the host sees a NACK
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (scl_fall) begin
              if (read_reg) begin
                sda_oe_reg <= ~mem_rdata[MSB];
                tx_reg     <= {mem_rdata[MSB-1:0], 1'b0};
                state_reg  <= ST_RDATA;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg  <= ST_INDEX;
              end
            end
          end
          ST_ACK_INDEX: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_WDATA;
            end
          end
          ST_ACK_WDATA: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              index_reg  <= index_reg + INDEX_STEP;
              state_reg  <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + BIT_COUNT_ONE;
            end else if (scl_fall) begin
              if (bit_cnt_reg == BIT_COUNT_FULL) begin
                bit_cnt_reg  <= BIT_COUNT_ZERO;
                sda_oe_reg   <= 1'b0;
                host_ack_reg <= 1'b0;
                index_reg    <= index_reg + INDEX_STEP;
                state_reg    <= ST_ACK_RDATA;
              end else begin
                sda_oe_reg <= ~tx_reg[MSB];
                tx_reg     <= {tx_reg[MSB-1:0], 1'b0};
              end
            end
          end
          ST_ACK_RDATA: begin
            if (scl_rise) begin
              // Host NACK ends the read; only STOP or START follow
              if (sda_sync_reg) begin
                state_reg <= ST_IGNORE;
              end else begin
                host_ack_reg <= 1'b1;
              end
            end else if (scl_fall && host_ack_reg) begin
              sda_oe_reg <= ~mem_rdata[MSB];
              tx_reg     <= {mem_rdata[MSB-1:0], 1'b0};
              state_reg  <= ST_RDATA;
            end
          end
          ST_IDLE, ST_IGNORE: begin
            sda_oe_reg <= 1'b0;
          end
          default: begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs; open drain, data is always zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sda_out    <= 1'b0;
      bus_active <= 1'b0;
    end else if (clk_en) begin
      sda_out    <= 1'b0;
      bus_active <= state_reg != ST_IDLE;
    end
  end

  assign sda_oe = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register store, written in step with the buffer push
  reg_mem u_reg_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .we      (push_reg),
    .waddr   (index_reg),
    .wdata   (rx_reg),
    .raddr   (index_reg),
    .rdata   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer, write side on ref_clk
  assign wbin_next = wbin_reg + PTR_STEP;
  // Full when write gray pointer is read pointer with both bits flipped
  assign buf_full  = wgray_reg == ~rgray_sync_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wbin_reg  <= PTR_ZERO;
      wgray_reg <= PTR_ZERO;
    end else if (clk_en && push_reg) begin
      buf_mem[wbin_reg[0]] <= '{index: index_reg, data: rx_reg};
      wbin_reg             <= wbin_next;
      wgray_reg            <= bin_to_gray(wbin_next);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rgray_meta_reg <= PTR_ZERO;
      rgray_sync_reg <= PTR_ZERO;
    end else if (clk_en) begin
      rgray_meta_reg <= rgray_reg;
      rgray_sync_reg <= rgray_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side on cfg_clk; reset is carried over as a level
  always_ff @(posedge cfg_clk) begin
    cfg_rst_meta_reg <= reset;
    cfg_rst_reg      <= cfg_rst_meta_reg;
  end

  always_ff @(posedge cfg_clk) begin
    if (cfg_rst_reg) begin
      wgray_meta_reg <= PTR_ZERO;
      wgray_sync_reg <= PTR_ZERO;
    end else begin
      wgray_meta_reg <= wgray_reg;
      wgray_sync_reg <= wgray_meta_reg;
    end
  end

  assign buf_empty = rgray_reg == wgray_sync_reg;
  // Receiver stall holds the word; the buffer then fills and NACKs data
  assign pop       = !buf_empty && (!cfg_valid || cfg_ready);
  assign rbin_next = rbin_reg + PTR_STEP;

  always_ff @(posedge cfg_clk) begin
    if (cfg_rst_reg) begin
      rbin_reg  <= PTR_ZERO;
      rgray_reg <= PTR_ZERO;
    end else if (pop) begin
      rbin_reg  <= rbin_next;
      rgray_reg <= bin_to_gray(rbin_next);
    end
  end

  always_ff @(posedge cfg_clk) begin
    if (cfg_rst_reg) begin
      cfg_valid <= 1'b0;
      cfg_word  <= '0;
    end else if (pop) begin
      cfg_valid <= 1'b1;
      cfg_word  <= buf_mem[rbin_reg[0]];
    end else if (cfg_ready) begin
      cfg_valid <= 1'b0;
    end
  end

  // Host side obligations kept outside: startup wait and SCL high in reset
endmodule // serial_host_command_slave

//--- serial_port_pkg.sv
package serial_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Slave addresses chosen by the strap, in 8-bit form with the R/W bit clear
  localparam logic [7:0] ADDR_STRAP_LOW  = 8'h40;
  localparam logic [7:0] ADDR_STRAP_HIGH = 8'h50;

  ////////////////////////////////////////////////////////////////////////////
  // Byte framing
  localparam int         BYTE_BITS      = 8;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
  localparam logic [3:0] BIT_COUNT_ONE  = 4'h1;
  localparam logic [7:0] INDEX_STEP     = 8'h01;
  localparam int         MSB            = BYTE_BITS - 1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int REF_CLK_KHZ            = 25000;
  localparam int SCL_MIN_KHZ            = 50;
  localparam int SCL_MAX_KHZ            = 1000;
  // Shortest SCL half period in ref_clk cycles, rounded down
  localparam int SCL_MIN_HALF_CYCLES    = REF_CLK_KHZ / (2 * SCL_MAX_KHZ);
  localparam int HOST_START_WAIT_CYCLES = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer pointers: one address bit plus wrap bit
  localparam int         BUF_PTR_W = 2;
  localparam int         BUF_DEPTH = 2;
  localparam logic [1:0] PTR_STEP  = 2'h1;
  localparam logic [1:0] PTR_ZERO  = 2'h0;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } cfg_write_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ACK_ADDR  = 10'h004,
    ST_INDEX     = 10'h008,
    ST_ACK_INDEX = 10'h010,
    ST_WDATA     = 10'h020,
    ST_ACK_WDATA = 10'h040,
    ST_RDATA     = 10'h080,
    ST_ACK_RDATA = 10'h100,
    ST_IGNORE    = 10'h200
  } link_state_t;

  function automatic logic [1:0] bin_to_gray(input logic [1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own);
    return rx[7:1] == own[7:1];
  endfunction

endpackage

//--- reg_mem.sv
module reg_mem (
  input  wire logic       ref_clk,
  input  wire logic       clk_en,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] cells [0:255];

  // No reset on the array; contents are whatever the host last wrote
  always_ff @(posedge ref_clk) begin
    if (clk_en && we) begin
      cells[waddr] <= wdata;
    end
  end

  // Registered read keeps the output path a single flop
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      rdata <= cells[raddr];
    end
  end
endmodule // reg_mem

//--- serial_host_command_slave_sva.sv
module serial_host_command_slave_sva (
  input wire logic                        ref_clk,
  input wire logic                        reset,
  input wire logic                        cfg_clk,
  input wire logic                        address_select_strap,
  input wire serial_port_pkg::bus_pins_t  bus_in,
  input wire logic                        sda_out,
  input wire logic                        sda_oe,
  input wire serial_port_pkg::cfg_write_t cfg_word,
  input wire logic                        cfg_valid,
  input wire logic                        cfg_ready,
  input wire logic [7:0]                  slave_address,
  input wire logic                        bus_active
);
  import serial_port_pkg::*;
  logic cfg_rst_meta_reg;
  logic cfg_rst_sync_reg;
  // Reset reaches the config side two cfg_clk edges late, as in the design
  always_ff @(posedge cfg_clk) begin
    cfg_rst_meta_reg <= reset;
    cfg_rst_sync_reg <= cfg_rst_meta_reg;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_addr_load;
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> ##[1:3] slave_address == (address_select_strap ? 8'h50 : 8'h40);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("slave address not loaded from strap");
  property p_addr_hold;
    @(posedge ref_clk) disable iff (reset)
    !$past(reset) && !$past(reset, 2) && !$past(reset, 3) |-> $stable(slave_address);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("slave address moved");
  property p_open_drain;
    @(posedge ref_clk) disable iff (reset) sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  // Drive moves only in the low half of SCL
  property p_sda_change;
    @(posedge ref_clk) disable iff (reset) $changed(sda_oe) |-> !bus_in.scl;
  endproperty
  a_sda_change: assert property (p_sda_change) else $error("sda drive changed with scl high");
  property p_ack_time;
    @(posedge ref_clk) disable iff (reset) $rose(sda_oe) |-> !bus_in.scl && $past(bus_in.scl, 5);
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("sda drive not tied to scl fall");
  property p_start;
    @(posedge ref_clk) disable iff (reset)
    bus_in.scl && $past(bus_in.scl) && $fell(bus_in.sda) |-> ##[1:5] bus_active;
  endproperty
  a_start: assert property (p_start) else $error("start not seen");
  property p_stop;
    @(posedge ref_clk) disable iff (reset)
    bus_in.scl && $past(bus_in.scl) && $rose(bus_in.sda) |-> ##[1:6] !bus_active;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not seen");
  property p_idle_quiet;
    @(posedge ref_clk) disable iff (reset) !bus_active && !$past(bus_active) |-> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven while idle");
  property p_cfg_hold;
    @(posedge cfg_clk) disable iff (reset || cfg_rst_sync_reg)
    cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_word);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config word dropped");
endmodule // serial_host_command_slave_sva

bind serial_host_command_slave serial_host_command_slave_sva chk (
  .ref_clk(ref_clk), .reset(reset), .cfg_clk(cfg_clk), .address_select_strap(address_select_strap),
  .bus_in(bus_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_word(cfg_word), .cfg_valid(cfg_valid),
  .cfg_ready(cfg_ready), .slave_address(slave_address), .bus_active(bus_active));

//--- host_model.sv
module host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  int half = 500;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic bitw(input logic b);
    #(half / 2) sda_low = !b;
    #(half / 2) scl = 1'b1;
    #(half) scl = 1'b0;
  endtask
  task automatic bitr(output logic b);
    #(half / 2) sda_low = 1'b0;
    #(half / 2) scl = 1'b1;
    b = sda_wire;
    #(half) scl = 1'b0;
  endtask
  task automatic start();
    #(half / 2) sda_low = 1'b0;
    #(half / 2) scl = 1'b1;
    #(half / 2) sda_low = 1'b1;
    #(half / 2) scl = 1'b0;
  endtask
  task automatic stop();
    #(half / 2) sda_low = 1'b1;
    #(half / 2) scl = 1'b1;
    #(half / 2) sda_low = 1'b0;
    #(half);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bitw(d[i]);
    bitr(b);
    ack = !b;
  endtask
  // Last byte left unacknowledged so the slave lets go
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitr(d[i]);
    bitw(last);
  endtask
endmodule // host_model

//--- serial_host_command_slave_tb.sv
module serial_host_command_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_port_pkg::*;
  logic       ref_clk = 1'b0, cfg_clk = 1'b0, reset = 1'b1, strap = 1'b0, cfg_ready = 1'b0, stall = 1'b0;
  logic       scl, host_low, sda_wire, sda_out, sda_oe, cfg_valid, bus_active;
  logic [7:0] slave_address, own, idx, d;
  logic [7:0] mem [256];
  bus_pins_t  pins;
  cfg_write_t cfg_word;
  cfg_write_t got[$], exp_q[$];
  int         errors = 0, cmp_count = 0;
  integer     seed = 32'h9ffe;
  assign sda_wire = !host_low && (!sda_oe || sda_out);
  assign pins = '{scl: scl, sda: sda_wire};
  always #20 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #80 cfg_clk = ~cfg_clk;
  end
  serial_host_command_slave DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .cfg_clk(cfg_clk),
    .address_select_strap(strap), .bus_in(pins), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_word(cfg_word),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .slave_address(slave_address), .bus_active(bus_active));
  host_model host (.scl(scl), .sda_low(host_low), .sda_wire(sda_wire));
  // Consumer stalls at random so the buffer sees back pressure
  always @(posedge cfg_clk) begin
    if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got.push_back(cfg_word);
    cfg_ready <= !stall && ($random(seed) % 3 != 0);
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_addr(input logic s);
    return s ? 8'h50 : 8'h40;
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic do_reset(input logic s);
    reset <= 1'b1;
    strap <= s;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    own = exp_addr(s);
    repeat (HOST_START_WAIT_CYCLES) @(posedge ref_clk);
    chk("slave address", {8'h0, own}, {8'h0, slave_address});
    strap <= !s;
    repeat (8) @(posedge ref_clk);
    chk("address hold", {8'h0, own}, {8'h0, slave_address});
  endtask
  task automatic xfer_w(input logic [7:0] a, input logic [7:0] ix, input logic [7:0] dv, input int n, input int room);
    logic ok;
    host.start();
    host.wbyte(a, ok);
    chk("addr ack", {15'h0, a == own}, {15'h0, ok});
    if (ok) begin
      host.wbyte(ix, ok);
      chk("index ack", 16'h1, {15'h0, ok});
      for (int k = 0; k < n; k++) begin
        host.wbyte(dv + k[7:0], ok);
        chk("data ack", {15'h0, k < room}, {15'h0, ok});
        if (k < room) begin
          mem[ix + k[7:0]] = dv + k[7:0];
          exp_q.push_back({ix + k[7:0], dv + k[7:0]});
        end
      end
    end
    host.stop();
  endtask
  task automatic xfer_r(input logic [7:0] ix);
    logic ok;
    logic [7:0] v;
    host.start();
    host.wbyte(own, ok);
    host.wbyte(ix, ok);
    host.start();
    host.wbyte(own | 8'h01, ok);
    chk("read addr ack", 16'h1, {15'h0, ok});
    host.rbyte(1'b1, v);
    host.stop();
    chk("read data", {8'h0, mem[ix]}, {8'h0, v});
  endtask
  task automatic drain();
    for (int t = 0; t < 300 && got.size() < exp_q.size(); t++) @(posedge cfg_clk);
    chk("word count", 16'(exp_q.size()), 16'(got.size()));
    while (got.size() > 0 && exp_q.size() > 0) chk("cfg word", exp_q.pop_front(), got.pop_front());
    got.delete();
    exp_q.delete();
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    xfer_w(8'h50, 8'h10, 8'h11, 1, 2);
    xfer_w(own, 8'h20, 8'ha5, 1, 9);
    xfer_r(8'h20);
    drain();
    $display("test strap low done");
    do_reset(1'b1);
    xfer_w(8'h40, 8'h10, 8'h11, 1, 2);
    repeat (6) begin
      idx = $random(seed);
      d = $random(seed);
      xfer_w(own, idx, d, 1 + ($random(seed) & 1), 9);
      xfer_r(idx);
    end
    drain();
    $display("test random done");
    stall = 1'b1;
    repeat (4) @(posedge cfg_clk);
    // Output register holds one word on top of the two buffered ones
    xfer_w(own, 8'h80, 8'h3c, 4, 3);
    stall = 1'b0;
    drain();
    $display("test buffer full done");
    host.half = 10000;
    xfer_w(own, 8'hff, 8'h5a, 1, 9);
    xfer_r(8'hff);
    host.half = 500;
    drain();
    $display("test slow clock done");
    end_sim();
  end
  // Whole run is near 2 ms of traffic
  initial begin
    #3000000;
    errors++;
    end_sim();
  end
endmodule // serial_host_command_slave_tb
